// ===== hdl/mdisp_top.sv
// Address decode, interrupt steering and power gating glue.
`timescale 1ns/100ps
`include "mdisp_consts.svh"
module mdisp_top (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Host bus pins.
  input  wire logic [15:0]             hostAddr,
  input  wire logic                    aen,
  // Peripheral pins.
  input  wire logic                    secondDrivePresentN,
  input  wire logic                    externalInterruptInput,
  input  wire logic                    powerValid,
  input  wire logic                    ringIndicate,
  // Sources and modes from neighbouring logic.
  input  wire logic                    serialIrq,
  input  wire logic                    parallelIrq,
  input  wire logic                    eppEcpMode,
  input  wire logic                    altStatusMode,
  // Configuration settings.
  input  wire logic [9:0]              gamePortBaseCfg,
  input  wire logic [1:0]              auxDecodeCtrlCfg,
  input  wire logic [7:0]              auxDecodeAddrLowCfg,
  input  wire logic [7:0]              auxDecodeAddrHighCfg,
  input  wire logic [3:0]              extIrqLineCfg,
  input  wire logic [3:0]              serialIrqLineCfg,
  input  wire logic [3:0]              parallelIrqLineCfg,
  // Base address write port.
  input  wire logic                    cfgWrite,
  input  wire mdisp_pkg::mdisp_target_t cfgTarget,
  input  wire logic [9:0]              cfgBase,
  input  wire logic                    cfgEnable,
  // Select pins.
  output logic                         auxBlockDecodeN,
  output logic                         auxDecodeOe,
  output logic                         gamePortSelectN,
  output logic                         ideCs0N,
  output logic                         ideCs1N,
  output logic                         pinOe,
  // Selects towards the device blocks.
  output logic                         floppySelect,
  output logic                         serial1Select,
  output logic                         serial2Select,
  output logic                         parallelSelect,
  // Interrupt lines.
  output logic [7:0]                   interruptOutLines,
  output logic [7:0]                   interruptOutOe,
  // Status towards the serial and floppy blocks.
  output logic                         ringIndicateOut,
  output logic                         floppyStatusADrive2
);
  import mdisp_pkg::*;

  mdisp_state_t s;
  mdisp_state_t n;
  logic [7:0]   extMask;
  logic [7:0]   serMask;
  logic [7:0]   parMask;
  logic [7:0]   sharedMask;
  logic [7:0]   selMask;
  logic [7:0]   lineLvl;
  logic [7:0]   pulseLow;
  logic         act;
  logic         gameHit;
  logic         auxHit;
  logic         ideSkip;
  logic [15:0]  auxBase;

  // Turns a line number 1 to 8 into a one-hot mask; 0 selects no line.
  function automatic logic [7:0] lineMask(input logic [3:0] sel);
    if (sel == `MDISP_LINE_NONE || sel > `MDISP_LINE_MAX) begin
      return 8'h00;
    end
    return 8'(8'h01 << (sel - 4'h1));
  endfunction

  // True when an address lies in the eight byte block at a base.
  function automatic logic hit8(input logic [9:0] a, input logic [9:0] b);
    return a[9:3] == b[9:3];
  endfunction

  // Line selection masks; a shared line is never driven as a level.
  assign extMask    = lineMask(extIrqLineCfg);
  assign serMask    = lineMask(serialIrqLineCfg);
  assign parMask    = lineMask(parallelIrqLineCfg);
  assign sharedMask = eppEcpMode ? parMask : 8'h00;
  assign selMask    = extMask | serMask | parMask;
  assign lineLvl    = (extMask & {8{s.extSync}}) |
                      (serMask & {8{serialIrq}}) |
                      (parMask & ~sharedMask & {8{parallelIrq}});

  // One pulser per interrupt line for the shared parallel interrupt.
  genvar gi;
  generate
    for (gi = 0; gi < `MDISP_LINE_COUNT; gi++) begin : g_line
      mdisp_pulse u_pulse (
        .clk      (clk),
        .rst      (rst),
        .enable   (sharedMask[gi] & s.pwrSync),
        .trigger  (parallelIrq),
        .pulseLow (pulseLow[gi])
      );
    end
  endgenerate

  // Address hits, qualified by AEN low and by valid power.
  assign act     = s.pwrSync & !s.aenSync;
  assign gameHit = act && (s.addrSync[9:0] == gamePortBaseCfg);
  assign auxBase = {auxDecodeAddrHighCfg, auxDecodeAddrLowCfg};
  assign ideSkip = (s.addrSync[9:0] == `MDISP_IDE_SKIP_A) ||
                   (s.addrSync[9:0] == `MDISP_IDE_SKIP_B);

  // Auxiliary block size chooses how many low address bits are ignored.
  always_comb begin
    auxHit = 1'h0;
    if (auxDecodeCtrlCfg == `MDISP_AUX_1B) begin
      auxHit = act && (s.addrSync == auxBase);
    end else if (auxDecodeCtrlCfg == `MDISP_AUX_8B) begin
      auxHit = act && (s.addrSync[15:3] == auxBase[15:3]);
    end else if (auxDecodeCtrlCfg == `MDISP_AUX_16B) begin
      auxHit = act && (s.addrSync[15:4] == auxBase[15:4]);
    end
  end

  // Next state: synchronisers, base registers, selects and line drivers.
  always_comb begin
    n = s;
    // Pins pass two flops; while power is invalid the bus, drive and interrupt inputs are frozen, ring indicate still passes.
    n.addrMeta = hostAddr;
    n.aenMeta  = aen;
    n.drvMeta  = secondDrivePresentN;
    n.extMeta  = externalInterruptInput;
    n.pwrMeta  = powerValid;
    n.ringMeta = ringIndicate;
    n.pwrSync  = s.pwrMeta;
    n.ringSync = s.ringMeta;
    if (s.pwrSync) begin
      n.addrSync = s.addrMeta;
      n.aenSync  = s.aenMeta;
      n.drvSync  = s.drvMeta;
      n.extSync  = s.extMeta;
    end
    // Base writes are taken only with valid power; besides these, only reset changes them.
    if (cfgWrite && s.pwrSync && cfgTarget <= MDISP_T_PAR) begin
      n.base[cfgTarget]      = cfgBase;
      n.devEnable[cfgTarget] = cfgEnable;
    end
    // Selects; each device block answers only once enabled.
    n.gameN     = !gameHit;
    n.auxN      = !auxHit;
    n.auxOe     = auxHit;
    n.pinOe     = s.pwrSync;
    n.ideCs0N   = !(act && s.devEnable[MDISP_T_IDE1] && !ideSkip &&
                    hit8(s.addrSync[9:0], s.base[MDISP_T_IDE1]));
    n.ideCs1N   = !(act && s.devEnable[MDISP_T_IDE2] && !ideSkip &&
                    s.addrSync[9:0] ==
                    10'(s.base[MDISP_T_IDE2] + `MDISP_IDE_ALT_OFS));
    n.floppySel = act && s.devEnable[MDISP_T_FLOPPY] &&
                  hit8(s.addrSync[9:0], s.base[MDISP_T_FLOPPY]) &&
                  s.addrSync[2:0] != `MDISP_FLOPPY_SKIP_OFS;
    n.ser1Sel   = act && s.devEnable[MDISP_T_SER1] &&
                  hit8(s.addrSync[9:0], s.base[MDISP_T_SER1]);
    n.ser2Sel   = act && s.devEnable[MDISP_T_SER2] &&
                  hit8(s.addrSync[9:0], s.base[MDISP_T_SER2]);
    n.parSel    = act && s.devEnable[MDISP_T_PAR] &&
                  hit8(s.addrSync[9:0], s.base[MDISP_T_PAR]) &&
                  (!s.addrSync[2] || eppEcpMode);
    // Lines: level drive, pulsed shared drive, serial line kept alive.
    n.irqOut = lineLvl & ~sharedMask;
    n.irqOe  = (sharedMask & pulseLow & {8{s.pwrSync}}) |
               (selMask & ~sharedMask & ({8{s.pwrSync}} | serMask));
    n.ringOut = s.ringSync;
    n.drvStatus = altStatusMode ? s.drvSync : 1'h0;
    // Synchronous reset: blocks disabled, selects idle, pins released.
    if (rst) begin
      n = '0;
      n.base[MDISP_T_FLOPPY] = `MDISP_FLOPPY_DEF;
      n.base[MDISP_T_IDE1]   = `MDISP_IDE1_DEF;
      n.base[MDISP_T_IDE2]   = `MDISP_IDE2_DEF;
      n.base[MDISP_T_SER1]   = `MDISP_SER1_DEF;
      n.base[MDISP_T_SER2]   = `MDISP_SER2_DEF;
      n.base[MDISP_T_PAR]    = `MDISP_PAR_DEF;
      n.auxN    = 1'h1;
      n.gameN   = 1'h1;
      n.ideCs0N = 1'h1;
      n.ideCs1N = 1'h1;
      n.aenSync = 1'h1;
      n.aenMeta = 1'h1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    s <= n;
  end

  // Outputs straight from the state flops.
  assign auxBlockDecodeN     = s.auxN;
  assign auxDecodeOe         = s.auxOe;
  assign gamePortSelectN     = s.gameN;
  assign ideCs0N             = s.ideCs0N;
  assign ideCs1N             = s.ideCs1N;
  assign pinOe               = s.pinOe;
  assign floppySelect        = s.floppySel;
  assign serial1Select       = s.ser1Sel;
  assign serial2Select       = s.ser2Sel;
  assign parallelSelect      = s.parSel;
  assign interruptOutLines   = s.irqOut;
  assign interruptOutOe      = s.irqOe;
  assign ringIndicateOut     = s.ringOut;
  assign floppyStatusADrive2 = s.drvStatus;

  drive_status_a: assert property (@(posedge clk) disable iff (rst)
    altStatusMode |=> s.drvStatus == $past(s.drvSync))
    else $error("Second drive status not reflected.");
  aux_decode_a: assert property (@(posedge clk) disable iff (rst)
    auxHit |=> !s.auxN && s.auxOe)
    else $error("Auxiliary decode missed its block.");
  aux_idle_a: assert property (@(posedge clk) disable iff (rst)
    !auxHit |=> s.auxN && !s.auxOe)
    else $error("Auxiliary decode fired outside its block.");
  ext_route_a: assert property (@(posedge clk) disable iff (rst)
    s.extSync && s.pwrSync && !eppEcpMode |=>
    (s.irqOut & s.irqOe & $past(extMask)) == $past(extMask))
    else $error("External interrupt not on its selected line.");
  power_hiz_a: assert property (@(posedge clk) disable iff (rst)
    !s.pwrSync |=> !s.pinOe && !s.auxOe &&
    (s.irqOe & ~$past(serMask)) == 8'h00)
    else $error("Output driven while power is invalid.");
  power_retain_a: assert property (@(posedge clk) disable iff (rst)
    !s.pwrSync |=> $stable(s.base) && $stable(s.devEnable))
    else $error("Register changed while power is invalid.");
  game_hit_a: assert property (@(posedge clk) disable iff (rst)
    gameHit |=> !s.gameN)
    else $error("Game port select missed a match.");
  game_miss_a: assert property (@(posedge clk) disable iff (rst)
    !gameHit |=> s.gameN)
    else $error("Game port select fired without a match.");
  ide_skip_a: assert property (@(posedge clk) disable iff (rst)
    ideSkip |=> s.ideCs0N && s.ideCs1N)
    else $error("IDE select on an excluded address.");
  serial_alive_a: assert property (@(posedge clk) disable iff (rst)
    serialIrq && !eppEcpMode |=>
    (s.irqOut & s.irqOe & $past(serMask)) == $past(serMask))
    else $error("Serial interrupt line not driven.");
  relocate_a: assert property (@(posedge clk) disable iff (rst)
    cfgWrite && s.pwrSync && cfgTarget == MDISP_T_FLOPPY |=>
    s.base[MDISP_T_FLOPPY] == $past(cfgBase))
    else $error("Floppy base not relocated.");
  unused_line_a: assert property (@(posedge clk) disable iff (rst)
    1'h1 |=> (s.irqOe & ~$past(selMask)) == 8'h00)
    else $error("Unselected interrupt line driven.");
endmodule // mdisp_top

// ===== hdl/mdisp_consts.svh
// Constants for the decode, interrupt steering and power gating block.
`ifndef MDISP_CONSTS_SVH
`define MDISP_CONSTS_SVH
`define MDISP_CLK_NS          4
`define MDISP_IRQ_PULSE_NS    40
`define MDISP_IRQ_PULSE_CYC   ((`MDISP_IRQ_PULSE_NS + `MDISP_CLK_NS - 1) / `MDISP_CLK_NS)
`define MDISP_IDE_SKIP_A      10'h377
`define MDISP_IDE_SKIP_B      10'h3F7
`define MDISP_IDE_ALT_OFS     10'h006
`define MDISP_FLOPPY_SKIP_OFS 3'h6
`define MDISP_FLOPPY_DEF      10'h3F0
`define MDISP_IDE1_DEF        10'h1F0
`define MDISP_IDE2_DEF        10'h3F0
`define MDISP_SER1_DEF        10'h3F8
`define MDISP_SER2_DEF        10'h2F8
`define MDISP_PAR_DEF         10'h378
`define MDISP_AUX_OFF         2'h0
`define MDISP_AUX_1B          2'h1
`define MDISP_AUX_8B          2'h2
`define MDISP_AUX_16B         2'h3
`define MDISP_LINE_NONE       4'h0
`define MDISP_LINE_MAX        4'h8
`define MDISP_LINE_COUNT      8
`endif

// ===== hdl/mdisp_pkg.sv
// Types shared by the decode, steering and power gating block.
package mdisp_pkg;
  // Shared interrupt pulse states, Gray coded along idle, low, hold.
  typedef enum logic [1:0] {
    MDISP_P_IDLE = 2'h0,
    MDISP_P_LOW  = 2'h1,
    MDISP_P_HOLD = 2'h3
  } mdisp_pulse_st_t;
  // Targets of a base address configuration write.
  typedef enum logic [2:0] {
    MDISP_T_FLOPPY = 3'h0,
    MDISP_T_IDE1   = 3'h1,
    MDISP_T_IDE2   = 3'h2,
    MDISP_T_SER1   = 3'h3,
    MDISP_T_SER2   = 3'h4,
    MDISP_T_PAR    = 3'h5
  } mdisp_target_t;
  // State of one shared interrupt pulser.
  typedef struct packed {
    mdisp_pulse_st_t st;
    logic [3:0]      cnt;
    logic            trigPrev;
  } mdisp_pulse_state_t;
  // State of the top module.
  typedef struct packed {
    logic [15:0]     addrMeta;
    logic [15:0]     addrSync;
    logic            aenMeta;
    logic            aenSync;
    logic            drvMeta;
    logic            drvSync;
    logic            extMeta;
    logic            extSync;
    logic            pwrMeta;
    logic            pwrSync;
    logic            ringMeta;
    logic            ringSync;
    logic [5:0][9:0] base;
    logic [5:0]      devEnable;
    logic            auxN;
    logic            auxOe;
    logic            gameN;
    logic            ideCs0N;
    logic            ideCs1N;
    logic            pinOe;
    logic            floppySel;
    logic            ser1Sel;
    logic            ser2Sel;
    logic            parSel;
    logic [7:0]      irqOut;
    logic [7:0]      irqOe;
    logic            ringOut;
    logic            drvStatus;
  } mdisp_state_t;
endpackage : mdisp_pkg

// ===== hdl/mdisp_pulse.sv
// Shared interrupt pulser: one low pulse per rising source edge.
`timescale 1ns/100ps
`include "mdisp_consts.svh"
module mdisp_pulse (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Source and mode.
  input  wire logic enable,
  input  wire logic trigger,
  // Pulse towards the line driver.
  output logic      pulseLow
);
  import mdisp_pkg::*;

  mdisp_pulse_state_t s;
  mdisp_pulse_state_t n;

  // A rising source edge starts a fixed low pulse, then waits for release.
  always_comb begin
    n = s;
    n.trigPrev = trigger;
    case (s.st)
      MDISP_P_IDLE: begin
        if (enable && trigger && !s.trigPrev) begin
          n.st = MDISP_P_LOW;
          n.cnt = 4'h1;
        end
      end
      MDISP_P_LOW: begin
        if (s.cnt == 4'(`MDISP_IRQ_PULSE_CYC)) begin
          n.st = MDISP_P_HOLD;
        end else begin
          n.cnt = s.cnt + 4'h1;
        end
      end
      MDISP_P_HOLD: begin
        if (!trigger) begin
          n.st = MDISP_P_IDLE;
        end
      end
      default: n.st = MDISP_P_IDLE;
    endcase
    if (!enable || rst) begin
      n.st = MDISP_P_IDLE;
      n.cnt = 4'h0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    s <= n;
  end

  assign pulseLow = (s.st == MDISP_P_LOW);

  pulse_len_a: assert property (@(posedge clk)
    disable iff (rst || !enable)
    $rose(pulseLow) |-> pulseLow[*8] ##1 pulseLow ##1 pulseLow ##1 !pulseLow)
    else $error("Shared interrupt pulse length is wrong.");
endmodule // mdisp_pulse

// ===== test/mdisp_far_model.sv
// Far-side model: host bus lines with pull-ups and the game port load.
`timescale 1ns/100ps
module mdisp_far_model (
  // Clock.
  input  wire logic       clk,
  // Interrupt lines from the block.
  input  wire logic [7:0] irqOut,
  input  wire logic [7:0] irqOe,
  // Select pins from the block.
  input  wire logic       auxN,
  input  wire logic       auxOe,
  input  wire logic       gameN,
  input  wire logic       pinOe,
  // Levels seen on the wires.
  output logic [7:0]      irqWire,
  output logic            auxWire,
  output logic            gameWire
);
  logic gameLast;

  // Bus interrupt lines carry pull-ups, so a released line reads high.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      irqWire[i] = irqOe[i] ? irqOut[i] : 1'b1;
    end
  end

  // The decode pin is open drain with an external pull-up.
  assign auxWire = auxOe ? auxN : 1'b1;

  // The game pin has no pull, so a floating pin shows the inverse level.
  always_ff @(posedge clk) begin
    if (pinOe) begin
      gameLast <= gameN;
    end
  end
  assign gameWire = pinOe ? gameN : ~gameLast;
endmodule // mdisp_far_model

// ===== test/mdisp_top_tb.sv
// Self-checking bench for the decode, steering and power gating block.
`timescale 1ns/100ps
`include "mdisp_consts.svh"
`define CHECK(got, exp) check_val(32'(got), 32'(exp))
module mdisp_top_tb;
  import mdisp_pkg::*;
  logic clk, rst, aen, drvN, extIn, pwr, ring, serIrq, parIrq, eppMode, altMode;
  logic [15:0] hostAddr;
  logic [9:0] gameCfg, cfgBase;
  logic [1:0] auxCtrl;
  logic [7:0] auxLow, auxHigh, irqLines, irqOe, irqWire;
  logic [3:0] extCfg, serCfg, parCfg;
  logic cfgWrite, cfgEnable, auxN, auxOe, gameN, cs0N, cs1N, pinOe;
  logic flopSel, ser1Sel, ser2Sel, parSel, ringOut, drvStat, auxWire, gameWire;
  mdisp_target_t cfgTarget;
  int errors, comparisons;

  mdisp_top DUT (.clk(clk), .rst(rst), .hostAddr(hostAddr), .aen(aen),
    .secondDrivePresentN(drvN), .externalInterruptInput(extIn),
    .powerValid(pwr), .ringIndicate(ring), .serialIrq(serIrq),
    .parallelIrq(parIrq), .eppEcpMode(eppMode), .altStatusMode(altMode),
    .gamePortBaseCfg(gameCfg), .auxDecodeCtrlCfg(auxCtrl),
    .auxDecodeAddrLowCfg(auxLow), .auxDecodeAddrHighCfg(auxHigh),
    .extIrqLineCfg(extCfg), .serialIrqLineCfg(serCfg),
    .parallelIrqLineCfg(parCfg), .cfgWrite(cfgWrite), .cfgTarget(cfgTarget),
    .cfgBase(cfgBase), .cfgEnable(cfgEnable), .auxBlockDecodeN(auxN),
    .auxDecodeOe(auxOe), .gamePortSelectN(gameN), .ideCs0N(cs0N),
    .ideCs1N(cs1N), .pinOe(pinOe), .floppySelect(flopSel),
    .serial1Select(ser1Sel), .serial2Select(ser2Sel),
    .parallelSelect(parSel), .interruptOutLines(irqLines),
    .interruptOutOe(irqOe), .ringIndicateOut(ringOut),
    .floppyStatusADrive2(drvStat));

  mdisp_far_model far (.clk(clk), .irqOut(irqLines), .irqOe(irqOe),
    .auxN(auxN), .auxOe(auxOe), .gameN(gameN), .pinOe(pinOe),
    .irqWire(irqWire), .auxWire(auxWire), .gameWire(gameWire));

  // Clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one value and counts the result.
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for clock edges, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Writes one block base and enable.
  task automatic cfg_base(input mdisp_target_t t, input logic [9:0] b);
    cfgTarget = t;
    cfgBase = b;
    cfgEnable = 1'b1;
    cfgWrite = 1'b1;
    tick(1);
    cfgWrite = 1'b0;
    tick(2);
  endtask

  // Presents a host address and waits for the decode to settle.
  task automatic put_addr(input logic [15:0] a, input logic e);
    hostAddr = a;
    aen = e;
    tick(4);
  endtask

  // Checks defaults, then writes every block base, relocating all but the floppy and the second IDE block, and decodes each block.
  task automatic test_decode;
    put_addr(16'h03F2, 1'b0);
    `CHECK(flopSel, 0);
    `CHECK(irqOe, 0);
    cfg_base(MDISP_T_FLOPPY, 10'h3F0);
    cfg_base(MDISP_T_IDE1, 10'h370);
    cfg_base(MDISP_T_IDE2, 10'h3F0);
    cfg_base(MDISP_T_SER1, 10'h2E8);
    cfg_base(MDISP_T_SER2, 10'h3E8);
    cfg_base(MDISP_T_PAR, 10'h278);
    put_addr(16'h0376, 1'b0);
    `CHECK(cs0N, 0);
    put_addr(16'h0377, 1'b0);
    `CHECK(cs0N, 1);
    put_addr(16'h03F6, 1'b0);
    `CHECK(cs1N, 0);
    `CHECK(flopSel, 0);
    put_addr(16'h03F7, 1'b0);
    `CHECK(cs1N, 1);
    `CHECK(flopSel, 1);
    cfg_base(MDISP_T_IDE1, 10'h3F0);
    put_addr(16'h03F7, 1'b0);
    `CHECK(cs0N, 1);
    cfg_base(MDISP_T_IDE2, 10'h371);
    put_addr(16'h0377, 1'b0);
    `CHECK(cs1N, 1);
    put_addr(16'h02EF, 1'b0);
    `CHECK(ser1Sel, 1);
    put_addr(16'h03EC, 1'b0);
    `CHECK(ser2Sel, 1);
    put_addr(16'h027B, 1'b0);
    `CHECK(parSel, 1);
    put_addr(16'h027C, 1'b0);
    `CHECK(parSel, 0);
    $display("test decode done");
  endtask

  // Game port select on exact match with AEN low only.
  task automatic test_game;
    gameCfg = 10'h201;
    put_addr(16'h0201, 1'b0);
    `CHECK(gameN, 0);
    `CHECK(gameWire, 0);
    `CHECK(pinOe, 1);
    put_addr(16'h0201, 1'b1);
    `CHECK(gameN, 1);
    put_addr(16'h0200, 1'b0);
    `CHECK(gameN, 1);
    $display("test game done");
  endtask

  // Auxiliary decode at every block size, last address of each block and the one above it.
  task automatic test_aux;
    int sz;
    auxHigh = 8'h03;
    auxLow = 8'h10;
    for (int m = 0; m < 4; m++) begin
      auxCtrl = 2'(m);
      sz = (m == 1) ? 1 : (m == 2) ? 8 : 16;
      put_addr(16'h0310 + 16'(sz - 1), 1'b0);
      `CHECK(auxN, m == 0);
      `CHECK(auxWire, m == 0);
      put_addr(16'h0310 + 16'(sz), 1'b0);
      `CHECK(auxN, 1);
    end
    put_addr(16'h1310, 1'b0);
    `CHECK(auxN, 1);
    $display("test aux done");
  endtask

  // External interrupt routed to each of the eight lines.
  task automatic test_steer;
    extIn = 1'b1;
    for (int k = 1; k <= `MDISP_LINE_COUNT; k++) begin
      extCfg = 4'(k);
      tick(4);
      `CHECK(irqOe, 8'h01 << (k - 1));
      `CHECK(irqLines[k - 1], 1);
    end
    extCfg = 4'h9;
    tick(3);
    `CHECK(irqOe, 0);
    extCfg = 4'h0;
    extIn = 1'b0;
    $display("test steer done");
  endtask

  // Shared parallel interrupt: one fixed pulse per rising edge.
  task automatic test_pulse;
    int cnt;
    parCfg = 4'h3;
    eppMode = 1'b1;
    put_addr(16'h027C, 1'b0);
    `CHECK(irqOe[2], 0);
    `CHECK(parSel, 1);
    for (int r = 0; r < 2; r++) begin
      cnt = 0;
      parIrq = 1'b1;
      for (int i = 0; i < 60; i++) begin
        tick(1);
        if (irqOe[2] === 1'b1 && irqWire[2] === 1'b0) begin
          cnt++;
        end
      end
      `CHECK(cnt, `MDISP_IRQ_PULSE_CYC);
      `CHECK(irqWire[2], 1);
      parIrq = 1'b0;
      tick(3);
    end
    eppMode = 1'b0;
    parCfg = 4'h0;
    $display("test pulse done");
  endtask

  // Second drive level reported only in alternate status mode.
  task automatic test_drive;
    altMode = 1'b1;
    drvN = 1'b0;
    tick(4);
    `CHECK(drvStat, 0);
    drvN = 1'b1;
    tick(4);
    `CHECK(drvStat, 1);
    altMode = 1'b0;
    tick(3);
    `CHECK(drvStat, 0);
    $display("test drive done");
  endtask

  // Power loss: pins released, serial path live, settings kept.
  task automatic test_power;
    serCfg = 4'h4;
    serIrq = 1'b1;
    extCfg = 4'h2;
    extIn = 1'b1;
    auxCtrl = 2'h1;
    put_addr(16'h0310, 1'b0);
    `CHECK(irqOe, 8'h0A);
    `CHECK(auxOe, 1);
    pwr = 1'b0;
    tick(4);
    `CHECK(irqOe, 8'h08);
    `CHECK(pinOe, 0);
    `CHECK(auxOe, 0);
    ring = 1'b1;
    tick(4);
    `CHECK(ringOut, 1);
    ring = 1'b0;
    tick(4);
    `CHECK(ringOut, 0);
    cfg_base(MDISP_T_SER1, 10'h3E8);
    pwr = 1'b1;
    tick(4);
    put_addr(16'h02E8, 1'b0);
    `CHECK(ser1Sel, 1);
    `CHECK(auxOe, 0);
    $display("test power done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    {aen, extIn, serIrq, parIrq, eppMode, altMode, ring} = '0;
    {drvN, pwr} = 2'b11;
    hostAddr = 16'h0000;
    {gameCfg, cfgBase} = '0;
    {auxCtrl, auxLow, auxHigh, extCfg, serCfg, parCfg} = '0;
    {cfgWrite, cfgEnable} = 2'b00;
    cfgTarget = MDISP_T_FLOPPY;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    tick(3);
    test_decode();
    test_game();
    test_aux();
    test_steer();
    test_pulse();
    test_drive();
    test_power();
    tally_and_finish();
  end
endmodule // mdisp_top_tb
